/* File: testbench/pim_checker_assertions.sv */
// port assertions for pulse input metering
`timescale 1ns/1ps
module pim_checker
  import pim_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic            mclk_in,
  input wire logic            rst_n_in,
  input wire logic            contact_input_one_in,
  input wire logic            contact_input_two_in,
  input wire logic            contact_input_three_in,
  input wire logic            contact_input_four_in,
  input wire logic            extra_inputs_present_in,
  input wire logic [7:0]      avs_address_in,
  input wire logic            avs_read_in,
  input wire logic            avs_write_in,
  input wire logic [31:0]     avs_writedata_in,
  input wire logic [3:0]      avs_byteenable_in,
  input wire logic [31:0]     avs_readdata_out,
  input wire logic            avs_waitrequest_out,
  input wire logic [N_IN-1:0] input_alarm_out,
  input wire logic            demand_sync_out,
  input wire logic [N_IN-1:0] tariff_select_out
);
  logic any_raw;
  // any contact high
  assign any_raw = contact_input_one_in | contact_input_two_in | contact_input_three_in
                   | contact_input_four_in;
  // single domain, async reset
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // bus handshake
  a_wait_first: assert property ($rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out)
    else $error("waitrequest low in first request cycle");
  a_wait_once: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest high for more than one cycle");
  a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without request");
  // input functions
  a_sync_single: assert property (demand_sync_out |=> !demand_sync_out)
    else $error("sync pulse longer than one cycle");
  a_sync_cause: assert property (demand_sync_out |-> $past(any_raw, 4))
    else $error("sync pulse without a high contact");
  a_func_exclusive: assert property ((tariff_select_out & input_alarm_out) == 4'h0)
    else $error("tariff and alarm on one input");
  a_absent_low: assert property (!extra_inputs_present_in [*5] |->
    tariff_select_out[3:2] == 2'h0 && input_alarm_out[3:2] == 2'h0)
    else $error("absent input drives an output");
  a_tariff_settle: assert property ($rose(tariff_select_out[0]) |->
    $past(contact_input_one_in, 4) && $past(contact_input_one_in, 5))
    else $error("tariff level rose without a steady contact");
  // main scenarios
  c_sync: cover property (demand_sync_out);
  c_alarm: cover property ($rose(input_alarm_out[1]));
  c_write: cover property (avs_write_in && !avs_waitrequest_out);
endmodule : pim_checker

bind pulse_input_metering pim_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .contact_input_one_in(contact_input_one_in),
  .contact_input_two_in(contact_input_two_in), .contact_input_three_in(contact_input_three_in),
  .contact_input_four_in(contact_input_four_in),
  .extra_inputs_present_in(extra_inputs_present_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .input_alarm_out(input_alarm_out),
  .demand_sync_out(demand_sync_out), .tariff_select_out(tariff_select_out));

/* File: testbench/pim_contacts.sv */
// transducer contact model driving the raw inputs
`timescale 1ns/1ps
module pim_contacts (
  input  wire logic       mclk_in,
  output logic      [3:0] contact_out
);
  initial contact_out = 4'h0;
  // hold one contact at a level for some cycles
  task automatic hold(input int idx, input logic lvl, input int cyc);
    @(posedge mclk_in);
    contact_out[idx] <= lvl;
    repeat (cyc - 1) @(posedge mclk_in);
  endtask : hold
  // whole on-then-off pulses, w cycles per level
  task automatic pulses(input int idx, input int n, input int w);
    repeat (n) begin
      hold(idx, 1'b1, w);
      hold(idx, 1'b0, w);
    end
  endtask : pulses
endmodule : pim_contacts

/* File: testbench/testbench.sv */
// self-checking bench for pulse input metering
`timescale 1ns/1ps
module testbench;
  import pim_pkg::*;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  logic            mclk_in, rst_n_in, extra_inputs_present_in;
  logic            avs_read_in, avs_write_in, avs_waitrequest_out, demand_sync_out;
  logic [7:0]      avs_address_in;
  logic [31:0]     avs_writedata_in, avs_readdata_out, rd;
  logic [3:0]      avs_byteenable_in, contact;
  logic [N_IN-1:0] input_alarm_out, tariff_select_out;
  int              fails, check_count, sync_seen;
  // address, write value, read back value
  row_t rows [7] = '{'{8'h10, 32'h0000_1032, 32'h0000_1032},
    '{8'h14, 32'h0000_007F, 32'h0000_0064}, '{8'h30, 32'h0098_967F, 32'h0098_967F},
    '{8'h34, 32'h0098_9680, 32'h0098_967F}, '{8'h28, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h24, 32'h0000_000F, 32'h0000_0003}, '{8'h04, 32'h0000_00FF, 32'h0000_0000}};
  // demand unit per unit code
  logic [3:0] dem [19] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3,
                           4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h9, 4'hB};

  pim_contacts u_src (.mclk_in(mclk_in), .contact_out(contact));
  pulse_input_metering #(.TICK_CYCLES(4)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .contact_input_one_in(contact[0]), .contact_input_two_in(contact[1]),
    .contact_input_three_in(contact[2]), .contact_input_four_in(contact[3]),
    .extra_inputs_present_in(extra_inputs_present_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .input_alarm_out(input_alarm_out),
    .demand_sync_out(demand_sync_out), .tariff_select_out(tariff_select_out));

  // clock
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // count sync pulses
  always @(posedge mclk_in) begin
    if (demand_sync_out === 1'b1) sync_seen <= sync_seen + 1;
  end
  // watchdog
  initial begin
    #(50 * 20000);
    fails++;
    complete_run();
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(nm, e, rd);
  endtask : rdchk
  task automatic note(input string nm);
    $display("test %s finished", nm);
  endtask : note
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    {fails, check_count, sync_seen} = '0;
    {rst_n_in, extra_inputs_present_in, avs_read_in, avs_write_in} = 4'h0;
    avs_address_in = 8'h00;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hF;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wd);
      rdchk("register", rows[i].adr, rows[i].exp);
    end
    for (int u = 0; u < 19; u++) begin
      wr(8'h20, 32'(u) << 8);
      rdchk("unit", 8'h20, {12'h000, dem[u], 3'h0, 5'(u), 8'h00});
    end
    wr(8'h20, 32'h0000_1300);
    rdchk("unit refused", 8'h20, 32'h000B_1200);
    note("registers");
    // bounce shorter than one 10 ms step, then a steady level
    wr(8'h10, 32'h0000_0301);
    u_src.pulses(0, 3, 8);
    check("chatter", 32'h0, {28'h0, tariff_select_out});
    u_src.hold(0, 1'b1, 36);
    check("early", 32'h0, {28'h0, tariff_select_out});
    repeat (16) @(posedge mclk_in);
    check("settled", 32'h1, {28'h0, tariff_select_out});
    wr(8'h10, 32'h0000_0300);
    u_src.hold(0, 1'b0, 8);
    check("no debounce", 32'h0, {28'h0, tariff_select_out});
    note("debounce");
    // channel 0 edges of both inputs, channel 1 whole pulses of input one
    wr(8'h10, 32'h0000_0200);
    wr(8'h14, 32'h0000_0200);
    wr(8'h20, 32'h0000_0003);
    wr(8'h24, 32'h0000_0011);
    wr(8'h30, 32'h0000_0005);
    u_src.pulses(0, 3, 10);
    u_src.pulses(1, 2, 10);
    u_src.hold(0, 1'b1, 10);
    rdchk("edge count", 8'h40, 32'd11);
    rdchk("edge cons", 8'h50, 32'h0000_0037);
    rdchk("pulse count", 8'h44, 32'd3);
    rdchk("pulse cons", 8'h54, 32'h01C9_C37D);
    note("metering");
    // plain counting with alarm
    wr(8'h14, 32'h0000_1000);
    u_src.hold(1, 1'b1, 10);
    check("alarm", 32'h2, {28'h0, input_alarm_out});
    u_src.hold(1, 1'b0, 10);
    u_src.pulses(1, 1, 10);
    rdchk("plain count", 8'h64, 32'd2);
    note("plain");
    // demand sync on input one
    wr(8'h10, 32'h0000_0100);
    u_src.hold(0, 1'b0, 10);
    u_src.pulses(0, 2, 10);
    check("sync pulses", 32'd2, 32'(sync_seen));
    rdchk("sync count", 8'h04, 32'd2);
    rdchk("no metering", 8'h40, 32'd11);
    note("demand sync");
    // inputs three and four present, then removed
    extra_inputs_present_in <= 1'b1;
    wr(8'h18, 32'h0000_0300);
    wr(8'h1C, 32'h0000_0200);
    wr(8'h24, 32'h0000_0008);
    rdchk("mask present", 8'h24, 32'h0000_0008);
    u_src.hold(2, 1'b1, 10);
    check("tariff three", 32'h4, {28'h0, tariff_select_out});
    u_src.pulses(3, 1, 10);
    rdchk("input four", 8'h44, 32'd5);
    extra_inputs_present_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    check("absent", 32'h0, {28'h0, tariff_select_out});
    note("extra inputs");
    // reset in mid-run
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rdchk("cfg reset", 8'h10, 32'h0);
    rdchk("weight reset", 8'h34, 32'h0);
    rdchk("accum reset", 8'h44, 32'h0);
    note("reset");
    complete_run();
  end
endmodule : testbench

/* File: verilog/pim_channels.sv */
// metering channel counters and consumption accumulators
`timescale 1ns/1ps
module pim_channels
  import pim_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  pim_ev_if.use_side                  ev,
  input  wire logic [N_CH-1:0][N_IN-1:0] mask_in,
  input  wire logic [N_CH-1:0]        whole_pulse_in,
  input  wire logic [N_CH-1:0][23:0]  weight_in,
  output logic      [N_CH-1:0][16:0]  accum_out,
  output logic      [N_CH-1:0][31:0]  cons_out
);
  // number of set bits in an event vector
  function automatic logic [2:0] count_ones(input logic [N_IN-1:0] v);
    count_ones = 3'h0;
    for (int k = 0; k < N_IN; k++) begin
      count_ones = count_ones + {2'h0, v[k]};
    end
  endfunction : count_ones

  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_ch
      logic [N_IN-1:0] evt;
      logic [2:0]      n;
      logic [17:0]     sum;
      // whole pulse counts on-then-off; edge mode counts both edges
      assign evt = mask_in[gc] & (whole_pulse_in[gc] ? (ev.change & ~ev.level)
                                                     : ev.change);  // RULE7 RULE8 RULE9
      assign n   = count_ones(evt);
      assign sum = {1'b0, accum_out[gc]} + {15'h0000, n};
      // accumulation wraps past the displayed limit
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          accum_out[gc] <= 17'h00000;
          cons_out[gc]  <= 32'h00000000;
        end else if (n != 3'h0) begin
          accum_out[gc] <= (sum >= {1'b0, ACC_WRAP}) ? 17'(sum - {1'b0, ACC_WRAP})
                                                     : sum[16:0];  // RULE14
          cons_out[gc]  <= cons_out[gc] + (32'(weight_in[gc]) * 32'(n));  // RULE10
        end
      end
    end
  endgenerate
endmodule : pim_channels

/* File: verilog/pim_debounce.sv */
// per-input debounce filters on a millisecond tick
`timescale 1ns/1ps
module pim_debounce
  import pim_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  tick_in,
  input  wire logic [N_IN-1:0]       raw_in,
  input  wire logic [N_IN-1:0][6:0]  steps_in,
  pim_ev_if.deb                      ev
);
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      logic       cand_reg;
      logic       level_reg;
      logic       change_reg;
      logic [9:0] ms_reg;
      logic [9:0] limit;
      assign limit = 10'(steps_in[gi] * DEB_STEP_MS);
      // restart on raw change, accept once stable for the interval
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cand_reg   <= 1'b0;
          level_reg  <= 1'b0;
          change_reg <= 1'b0;
          ms_reg     <= 10'h000;
        end else begin
          change_reg <= 1'b0;
          if (raw_in[gi] != cand_reg) begin
            cand_reg <= raw_in[gi];  // RULE15
            ms_reg   <= 10'h000;  // RULE15
          end else if (cand_reg != level_reg) begin
            if (ms_reg >= limit) begin
              level_reg  <= cand_reg;  // RULE1
              change_reg <= 1'b1;
            end else if (tick_in) begin
              ms_reg <= ms_reg + 10'h001;  // RULE15
            end
          end else begin
            ms_reg <= 10'h000;  // RULE1
          end
        end
      end
      assign ev.level[gi]  = level_reg;
      assign ev.change[gi] = change_reg;
    end
  endgenerate
endmodule : pim_debounce

/* File: verilog/pim_ev_if.sv */
// debounced input levels and accepted-change strobes
`timescale 1ns/1ps
interface pim_ev_if;
  import pim_pkg::*;
  logic [N_IN-1:0] level;
  logic [N_IN-1:0] change;
  modport deb (output level, output change);
  modport use_side (input level, input change);
endinterface : pim_ev_if

/* File: verilog/pim_pkg.sv */
// shared constants, encodings and decode helpers for pulse input metering
package pim_pkg;
  localparam int N_IN = 4;
  localparam int N_CH = 2;
  localparam int N_FIXED = 2;
  // timing and limits
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DEB_STEP_MS = 10;
  localparam int DEB_MAX_MS = 1000;
  localparam logic [6:0] DEB_MAX_STEPS = 7'(DEB_MAX_MS / DEB_STEP_MS);
  localparam logic [16:0] ACC_WRAP = 17'h186A0;
  localparam logic [23:0] WEIGHT_MAX = 24'h98967F;
  localparam logic [4:0] UNIT_COUNT = 5'h13;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SYNC_COUNT = 8'h04;
  localparam logic [7:0] OFS_IN_CFG = 8'h10;
  localparam logic [7:0] OFS_CH_CFG = 8'h20;
  localparam logic [7:0] OFS_CH_WEIGHT = 8'h30;
  localparam logic [7:0] OFS_CH_ACCUM = 8'h40;
  localparam logic [7:0] OFS_CH_CONS = 8'h50;
  localparam logic [7:0] OFS_IN_COUNT = 8'h60;
  // field positions
  localparam int IN_DEB_LSB = 0;
  localparam int IN_FUNC_LSB = 8;
  localparam int IN_ALARM_BIT = 12;
  localparam int CH_MASK_LSB = 0;
  localparam int CH_MODE_BIT = 4;
  localparam int CH_UNIT_LSB = 8;
  localparam int CH_DEM_LSB = 16;
  // values after reset
  localparam logic [6:0] DEB_RST = 7'h00;
  localparam logic [23:0] WEIGHT_RST = 24'h000000;
  localparam logic [4:0] UNIT_RST = 5'h00;

  typedef enum logic [1:0] {
    FN_NORMAL = 2'h0, FN_DEMAND_SYNC = 2'h1, FN_METERING = 2'h2, FN_TARIFF = 2'h3
  } in_func_t;

  // unit codes 0..18: none, Wh, kWh, MWh, VARh, kVARh, MVARh, VAh, kVAh, MVAh,
  // gal, BTU, L, m3, MCF, lbs, kg, klbs, therm
  typedef enum logic [3:0] {
    DM_NONE = 4'h0, DM_KW = 4'h1, DM_KVAR = 4'h2, DM_KVA = 4'h3, DM_GPH = 4'h4,
    DM_BTUH = 4'h5, DM_LPH = 4'h6, DM_M3H = 4'h7, DM_CFM = 4'h8, DM_LBH = 4'h9,
    DM_KGH = 4'hA, DM_THMH = 4'hB
  } demand_t;

  // derived demand unit of a unit code
  function automatic demand_t demand_of(input logic [4:0] unit);
    case (unit)
      5'h01, 5'h02, 5'h03: demand_of = DM_KW;
      5'h04, 5'h05, 5'h06: demand_of = DM_KVAR;
      5'h07, 5'h08, 5'h09: demand_of = DM_KVA;
      5'h0A: demand_of = DM_GPH;
      5'h0B: demand_of = DM_BTUH;
      5'h0C: demand_of = DM_LPH;
      5'h0D: demand_of = DM_M3H;
      5'h0E: demand_of = DM_CFM;
      5'h0F, 5'h11: demand_of = DM_LBH;
      5'h10: demand_of = DM_KGH;
      5'h12: demand_of = DM_THMH;
      default: demand_of = DM_NONE;
    endcase
  endfunction : demand_of
endpackage : pim_pkg

/* File: verilog/pulse_input_metering.sv */
// pulse input metering top: pin sync, ms tick, functions, avalon registers
// What this block does
// RULE1: accept a level change only after it stays stable for the debounce time
// RULE2: debounce per input, 0 to 1000 ms in 10 ms steps
// RULE3: plain function counts every valid pulse, may drive an input alarm
// RULE4: demand sync function uses each valid pulse to align demand period
// RULE5: metering function forwards valid pulses to the assigned channel
// RULE6: tariff function routes the debounced level to tariff selection
// RULE7: a channel counts pulses from every input assigned to it
// RULE8: whole-pulse mode adds one per full on-then-off cycle
// RULE9: edge mode adds one on every valid change in either direction
// RULE10: per-channel pulse weight from 0 to 99.99999
// RULE11: per-channel unit code from nineteen choices
// RULE12: demand unit follows the unit code automatically
// RULE13: inputs one and two always assignable, three and four only if present
// RULE14: channel accumulation runs 0 to 99999 then wraps to zero
// RULE15: debounce timer runs on 1 ms tick, restarts on raw change, zero passes
`timescale 1ns/1ps
module pulse_input_metering
  import pim_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        contact_input_one_in,
  input  wire logic        contact_input_two_in,
  input  wire logic        contact_input_three_in,
  input  wire logic        contact_input_four_in,
  input  wire logic        extra_inputs_present_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [N_IN-1:0]  input_alarm_out,
  output logic             demand_sync_out,
  output logic [N_IN-1:0]  tariff_select_out
);
  localparam int TW = $clog2(TICK_CYCLES);

  // merge write data into an old word by byte lanes
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : be_merge

  // true when an address falls in a 16-byte register block
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
    in_block = (a[7:4] == base[7:4]);
  endfunction : in_block

  // pin synchronisers
  logic [N_IN:0] sync1_reg;
  logic [N_IN:0] sync2_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {extra_inputs_present_in, contact_input_four_in,
                    contact_input_three_in, contact_input_two_in,
                    contact_input_one_in};
      sync2_reg <= sync1_reg;
    end
  end

  logic            extra_present;
  logic [N_IN-1:0] present;
  logic [N_IN-1:0] raw_eff;
  assign extra_present = sync2_reg[N_IN];
  assign present       = {extra_present, extra_present, 2'b11};  // RULE13
  assign raw_eff       = sync2_reg[N_IN-1:0] & present;  // RULE13

  // free-running millisecond tick
  logic [TW-1:0] tick_cnt_reg;
  logic          tick_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;  // RULE15
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // avalon handshake: one wait cycle, then accept
  logic ack_reg;
  logic req;
  logic wr_acc;
  logic [1:0] idx;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign wr_acc              = avs_write_in & ack_reg;
  assign idx                 = avs_address_in[3:2];

  // per-input configuration
  logic [N_IN-1:0][6:0] deb_steps_reg;
  in_func_t             func_reg [N_IN];
  logic [N_IN-1:0]      alarm_en_reg;
  logic [N_IN-1:0][31:0] in_cfg_word;
  logic [31:0]           in_cfg_new;
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_cfgw
      always_comb begin
        in_cfg_word[gi] = 32'h00000000;
        in_cfg_word[gi][IN_DEB_LSB +: 7]  = deb_steps_reg[gi];
        in_cfg_word[gi][IN_FUNC_LSB +: 2] = func_reg[gi];
        in_cfg_word[gi][IN_ALARM_BIT]     = alarm_en_reg[gi];
      end
    end
  endgenerate
  assign in_cfg_new = be_merge(in_cfg_word[idx], avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      deb_steps_reg <= {N_IN{DEB_RST}};
      alarm_en_reg  <= '0;
      for (int i = 0; i < N_IN; i++) begin
        func_reg[i] <= FN_NORMAL;
      end
    end else if (wr_acc && in_block(avs_address_in, OFS_IN_CFG)) begin
      deb_steps_reg[idx] <= (in_cfg_new[IN_DEB_LSB +: 7] > DEB_MAX_STEPS)
                            ? DEB_MAX_STEPS : in_cfg_new[IN_DEB_LSB +: 7];  // RULE2
      func_reg[idx]      <= in_func_t'(in_cfg_new[IN_FUNC_LSB +: 2]);
      alarm_en_reg[idx]  <= in_cfg_new[IN_ALARM_BIT];
    end
  end

  // debounce filters
  pim_ev_if ev ();
  pim_debounce u_debounce (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tick_in  (tick_reg),
    .raw_in   (raw_eff),
    .steps_in (deb_steps_reg),
    .ev       (ev.deb)
  );

  // function select vectors
  logic [N_IN-1:0] is_normal;
  logic [N_IN-1:0] is_sync;
  logic [N_IN-1:0] is_meter;
  logic [N_IN-1:0] is_tariff;
  logic [N_IN-1:0] on_edge;
  logic [N_IN-1:0] off_edge;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_fn
      assign is_normal[gi] = (func_reg[gi] == FN_NORMAL);
      assign is_sync[gi]   = (func_reg[gi] == FN_DEMAND_SYNC);
      assign is_meter[gi]  = (func_reg[gi] == FN_METERING) & present[gi];
      assign is_tariff[gi] = (func_reg[gi] == FN_TARIFF);
    end
  endgenerate
  assign on_edge  = ev.change & ev.level;
  assign off_edge = ev.change & ~ev.level;

  // plain pulse counters and alarm feed
  logic [N_IN-1:0][31:0] in_count_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_count_reg    <= '0;
      input_alarm_out <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (off_edge[i] && is_normal[i]) begin
          in_count_reg[i] <= in_count_reg[i] + 32'h00000001;  // RULE3
        end
      end
      input_alarm_out <= ev.level & alarm_en_reg & is_normal & present;  // RULE3 RULE13
    end
  end

  // demand period alignment strobe
  logic [31:0] sync_count_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      demand_sync_out <= 1'b0;
      sync_count_reg  <= 32'h00000000;
    end else begin
      demand_sync_out <= |(on_edge & is_sync);  // RULE4
      if (|(on_edge & is_sync)) begin
        sync_count_reg <= sync_count_reg + 32'h00000001;
      end
    end
  end

  // tariff selector levels
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tariff_select_out <= '0;
    end else begin
      tariff_select_out <= ev.level & is_tariff & present;  // RULE6 RULE13
    end
  end

  // channel configuration
  logic [N_CH-1:0][N_IN-1:0] mask_reg;
  logic [N_CH-1:0]           whole_pulse_reg;
  logic [N_CH-1:0][4:0]      unit_reg;
  logic [N_CH-1:0][23:0]     weight_reg;
  logic [N_CH-1:0][N_IN-1:0] mask_eff;
  logic [N_CH-1:0][31:0]     ch_cfg_word;
  logic [31:0]               ch_cfg_new;
  logic [31:0]               weight_new;
  logic                      ch_ok;
  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_chw
      assign mask_eff[gc] = mask_reg[gc] & is_meter;  // RULE5 RULE13
      always_comb begin
        ch_cfg_word[gc] = 32'h00000000;
        ch_cfg_word[gc][CH_MASK_LSB +: N_IN] = mask_reg[gc];
        ch_cfg_word[gc][CH_MODE_BIT]         = whole_pulse_reg[gc];
        ch_cfg_word[gc][CH_UNIT_LSB +: 5]    = unit_reg[gc];
        ch_cfg_word[gc][CH_DEM_LSB +: 4]     = demand_of(unit_reg[gc]);  // RULE12
      end
    end
  endgenerate
  assign ch_ok      = (32'(idx) < N_CH);
  assign ch_cfg_new = be_merge(ch_cfg_word[idx[0]], avs_writedata_in, avs_byteenable_in);
  assign weight_new = be_merge({8'h00, weight_reg[idx[0]]}, avs_writedata_in,
                               avs_byteenable_in);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_reg        <= '0;
      whole_pulse_reg <= '0;
      unit_reg        <= {N_CH{UNIT_RST}};
    end else if (wr_acc && ch_ok && in_block(avs_address_in, OFS_CH_CFG)) begin
      mask_reg[idx[0]]        <= ch_cfg_new[CH_MASK_LSB +: N_IN] & present;  // RULE13
      whole_pulse_reg[idx[0]] <= ch_cfg_new[CH_MODE_BIT];
      if (ch_cfg_new[CH_UNIT_LSB +: 5] < UNIT_COUNT) begin
        unit_reg[idx[0]] <= ch_cfg_new[CH_UNIT_LSB +: 5];  // RULE11
      end
    end
  end

  // pulse weight in units of 0.00001, clamped
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      weight_reg <= {N_CH{WEIGHT_RST}};
    end else if (wr_acc && ch_ok && in_block(avs_address_in, OFS_CH_WEIGHT)) begin
      weight_reg[idx[0]] <= (weight_new > {8'h00, WEIGHT_MAX}) ? WEIGHT_MAX
                                                               : weight_new[23:0];  // RULE10
    end
  end

  // channel counters
  logic [N_CH-1:0][16:0] accum;
  logic [N_CH-1:0][31:0] cons;
  pim_channels u_channels (
    .mclk_in        (mclk_in),
    .rst_n_in       (rst_n_in),
    .ev             (ev.use_side),
    .mask_in        (mask_eff),
    .whole_pulse_in (whole_pulse_reg),
    .weight_in      (weight_reg),
    .accum_out      (accum),
    .cons_out       (cons)
  );

  // read mux, unmapped reads give zero
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h00000000;
    if (avs_address_in == OFS_STATUS) begin
      rdata_next[N_IN-1:0]   = ev.level;
      rdata_next[7:4]        = present;
      rdata_next[11:8]       = tariff_select_out;
    end else if (avs_address_in == OFS_SYNC_COUNT) begin
      rdata_next = sync_count_reg;
    end else if (in_block(avs_address_in, OFS_IN_CFG)) begin
      rdata_next = in_cfg_word[idx];
    end else if (in_block(avs_address_in, OFS_IN_COUNT)) begin
      rdata_next = in_count_reg[idx];
    end else if (ch_ok && in_block(avs_address_in, OFS_CH_CFG)) begin
      rdata_next = ch_cfg_word[idx[0]];
    end else if (ch_ok && in_block(avs_address_in, OFS_CH_WEIGHT)) begin
      rdata_next = {8'h00, weight_reg[idx[0]]};
    end else if (ch_ok && in_block(avs_address_in, OFS_CH_ACCUM)) begin
      rdata_next = {15'h0000, accum[idx[0]]};  // RULE14
    end else if (ch_ok && in_block(avs_address_in, OFS_CH_CONS)) begin
      rdata_next = cons[idx[0]];
    end
  end

  // read data captured in the wait cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && !ack_reg) begin
      avs_readdata_out <= rdata_next;
    end
  end
endmodule : pulse_input_metering
